// >>> hw/pin_mux_cfg.svh
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// ==========================================================
// sizes
`define PM_NUM_PINS      32
`define PM_NUM_PAIRS     16
`define PM_SEL_W         3
`define PM_NUM_CODES     8

// ==========================================================
// pin roles
`define PM_DBG_PIN       31
`define PM_TWO_WIRE_MASK 32'h00c0c000
`define PM_PULLUP_MASK   32'h03000000

// ==========================================================
// reset values
`define PM_EN_RST        32'h00000000
`define PM_SEL_RST       3'h0

`endif

// >>> hw/pin_mux_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_cfg.svh"
module pin_mux_config
  import pin_mux_pkg::*;
(
  // system
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // write port
  input  wire logic                     wr_valid,
  output logic                          wr_ready,
  input  wire logic                     wr_kind,
  input  wire logic [4:0]               wr_pin,
  input  wire logic [`PM_SEL_W-1:0]     wr_data,
  input  wire logic                     wr_two_wire,
  output logic                          wr_reject_r,
  // pad control and readback
  output logic      [`PM_NUM_PINS-1:0]  gpio_pullup_en_r,
  output logic      [`PM_NUM_PINS-1:0]  owned_by_periph_r,
  output logic                          debug_active_r,
  // configuration link
  pin_mux_if.config_end                 cfg
);

  // ==========================================================
  // registers
  logic [`PM_NUM_PINS-1:0]                 pin_configuration_reg_r;
  logic [`PM_NUM_PAIRS-1:0][`PM_SEL_W-1:0] even_sel_r;
  logic [`PM_NUM_PAIRS-1:0][`PM_SEL_W-1:0] odd_sel_r;
  logic                                    bad_two_wire;
  logic [`PM_NUM_PINS-1:0]                 two_wire_mask;

  assign two_wire_mask = `PM_TWO_WIRE_MASK;
  assign wr_ready      = 1'b1;
  // two-wire bus only on capable pads
  assign bad_two_wire  = wr_two_wire && (wr_kind == WR_SELECT) &&
                         !two_wire_mask[wr_pin];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_configuration_reg_r <= `PM_EN_RST;
    end else if (wr_valid && wr_kind == WR_ENABLE) begin
      pin_configuration_reg_r[wr_pin] <= wr_data[0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      even_sel_r <= '0;
      odd_sel_r  <= '0;
    end else if (wr_valid && wr_kind == WR_SELECT && !bad_two_wire) begin
      if (wr_pin[0]) begin
        odd_sel_r[wr_pin[4:1]] <= wr_data;
      end else begin
        even_sel_r[wr_pin[4:1]] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_reject_r <= 1'b0;
    end else begin
      wr_reject_r <= wr_valid && bad_two_wire;
    end
  end

  // unconnected pins 24 and 25 held at a defined level while their mux enable bit is clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_pullup_en_r <= `PM_PULLUP_MASK;
    end else begin
      gpio_pullup_en_r <= `PM_PULLUP_MASK & ~pin_configuration_reg_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      owned_by_periph_r <= '0;
      debug_active_r    <= 1'b0;
    end else begin
      owned_by_periph_r <= cfg.pin_owned_by_periph;
      debug_active_r    <= cfg.debug_active;
    end
  end

  assign cfg.peripheral_mux_enable    = pin_configuration_reg_r;
  assign cfg.even_pin_function_select = even_sel_r;
  assign cfg.odd_pin_function_select  = odd_sel_r;

endmodule
`default_nettype wire

// >>> hw/pin_mux_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_cfg.svh"
interface pin_mux_if;
  logic [`PM_NUM_PINS-1:0]                   peripheral_mux_enable;
  logic [`PM_NUM_PAIRS-1:0][`PM_SEL_W-1:0]   even_pin_function_select;
  logic [`PM_NUM_PAIRS-1:0][`PM_SEL_W-1:0]   odd_pin_function_select;
  logic [`PM_NUM_PINS-1:0]                   pin_owned_by_periph;
  logic                                      debug_active;

  modport device (
    input  peripheral_mux_enable,
    input  even_pin_function_select,
    input  odd_pin_function_select,
    output pin_owned_by_periph,
    output debug_active
  );
  modport config_end (
    output peripheral_mux_enable,
    output even_pin_function_select,
    output odd_pin_function_select,
    input  pin_owned_by_periph,
    input  debug_active
  );
endinterface
`default_nettype wire

// >>> hw/pin_mux_pkg.sv
package pin_mux_pkg;
  // function codes, A counting upward; code 5 has no function
  typedef enum logic [2:0] {
    FUNC_A   = 3'h0,
    FUNC_B   = 3'h1,
    FUNC_C   = 3'h2,
    FUNC_D   = 3'h3,
    FUNC_E   = 3'h4,
    FUNC_RSV = 3'h5,
    FUNC_G   = 3'h6,
    FUNC_H   = 3'h7
  } func_code_t;

  typedef enum logic {
    WR_ENABLE = 1'b0,
    WR_SELECT = 1'b1
  } wr_kind_t;
endpackage

// >>> hw/port_pin_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_cfg.svh"
module port_pin_function_mux
  import pin_mux_pkg::*;
(
  // system
  input  wire logic                                     clk_sys,
  input  wire logic                                     resetn,
  // configuration link
  pin_mux_if.device                                     cfg,
  // debugger detection
  input  wire logic                                     debugger_present,
  // general-purpose I/O logic
  input  wire logic [`PM_NUM_PINS-1:0]                  gpio_out,
  input  wire logic [`PM_NUM_PINS-1:0]                  gpio_oe,
  output logic      [`PM_NUM_PINS-1:0]                  gpio_in_r,
  // peripherals, indexed by function code
  input  wire logic [`PM_NUM_CODES-1:0][`PM_NUM_PINS-1:0] func_out,
  input  wire logic [`PM_NUM_CODES-1:0][`PM_NUM_PINS-1:0] func_oe,
  output logic      [`PM_NUM_CODES-1:0][`PM_NUM_PINS-1:0] func_in_r,
  // package pins
  input  wire logic [`PM_NUM_PINS-1:0]                  pin_i,
  output logic      [`PM_NUM_PINS-1:0]                  pin_o_r,
  output logic      [`PM_NUM_PINS-1:0]                  pin_oe_r
);

  // ==========================================================
  // selection decode
  logic debug_active_r;

  // even pins read the even field, odd pins the odd field
  function automatic logic [`PM_SEL_W-1:0] pin_code(input int p);
    if (p % 2 == 0) begin
      pin_code = cfg.even_pin_function_select[p/2];
    end else begin
      pin_code = cfg.odd_pin_function_select[p/2];
    end
  endfunction

  // reserved code falls back to gpio so the pin never floats
  function automatic logic periph_owned(input int p);
    if (p == `PM_DBG_PIN && debug_active_r) begin
      periph_owned = 1'b1;
    end else begin
      periph_owned = cfg.peripheral_mux_enable[p] &&
                     (pin_code(p) != FUNC_RSV);
    end
  endfunction

  function automatic logic [`PM_SEL_W-1:0] eff_code(input int p);
    if (p == `PM_DBG_PIN && debug_active_r) begin
      eff_code = FUNC_G;
    end else begin
      eff_code = pin_code(p);
    end
  endfunction

  // ==========================================================
  // debugger tracking: hot or cold attach, no software step
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      debug_active_r <= 1'b0;
    end else begin
      debug_active_r <= debugger_present;
    end
  end

  assign cfg.debug_active = debug_active_r;

  // ==========================================================
  // per-pin routing
  genvar gp;
  generate
    for (gp = 0; gp < `PM_NUM_PINS; gp++) begin : g_pin
      logic                 own;
      logic [`PM_SEL_W-1:0] code;
      assign own  = periph_owned(gp);
      assign code = eff_code(gp);
      assign cfg.pin_owned_by_periph[gp] = own;

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          pin_o_r[gp]  <= 1'b0;
          pin_oe_r[gp] <= 1'b0;
        end else if (own) begin
          pin_o_r[gp]  <= func_out[code][gp];
          pin_oe_r[gp] <= func_oe[code][gp];
        end else begin
          pin_o_r[gp]  <= gpio_out[gp];
          pin_oe_r[gp] <= gpio_oe[gp];
        end
      end

      // input side: gpio always sees the pin, each function only when selected
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          gpio_in_r[gp] <= 1'b0;
        end else begin
          gpio_in_r[gp] <= pin_i[gp];
        end
      end

      genvar gf;
      for (gf = 0; gf < `PM_NUM_CODES; gf++) begin : g_fn
        always_ff @(posedge clk_sys or negedge resetn) begin
          if (!resetn) begin
            func_in_r[gf][gp] <= 1'b0;
          end else begin
            func_in_r[gf][gp] <= own && (code == gf) &&
                                 pin_i[gp];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> tb/pin_mux_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_cfg.svh"
module pin_mux_checker (
  // system
  input wire logic                        clk_sys,
  input wire logic                        resetn,
  // configuration link
  input wire logic [`PM_NUM_PINS-1:0]     peripheral_mux_enable,
  input wire logic [15:0][`PM_SEL_W-1:0]  even_pin_function_select,
  input wire logic [15:0][`PM_SEL_W-1:0]  odd_pin_function_select,
  input wire logic [`PM_NUM_PINS-1:0]     pin_owned_by_periph,
  input wire logic                        debug_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // ownership
  sequence dbg_held_s;
    debug_active [*2];
  endsequence
  gpio_default_a: assert property ((pin_owned_by_periph
    & ~peripheral_mux_enable & ~{debug_active, 31'h0}) == 32'h0)
    else $error("pin owned without enable");
  even_select_a: assert property (peripheral_mux_enable[4] |->
    pin_owned_by_periph[4] == (even_pin_function_select[2] != 3'h5))
    else $error("even pin ownership wrong");
  odd_select_a: assert property (peripheral_mux_enable[5] |->
    pin_owned_by_periph[5] == (odd_pin_function_select[2] != 3'h5))
    else $error("odd pin ownership wrong");
  top_pair_a: assert property (debug_active ||
    pin_owned_by_periph[30] == (peripheral_mux_enable[30]
    && even_pin_function_select[15] != 3'h5))
    else $error("pin 30 ownership wrong");
  debug_owns_a: assert property (debug_active |->
    pin_owned_by_periph[31]) else $error("debug pin not taken");
  debug_hold_a: assert property (dbg_held_s |->
    $stable(pin_owned_by_periph[31])) else $error("debug pin dropped");
  debug_release_a: assert property ($fell(debug_active)
    && !peripheral_mux_enable[31] |-> !pin_owned_by_periph[31])
    else $error("debug pin kept after release");
  owner_stable_a: assert property ($stable(peripheral_mux_enable)
    && $stable(even_pin_function_select) && $stable(debug_active)
    && $stable(odd_pin_function_select) |-> $stable(pin_owned_by_periph))
    else $error("ownership moved by itself");
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_cfg.svh"
module tb;
  import pin_mux_pkg::*;
  logic clk_sys = 0, resetn = 0, wv = 0, wk = 0, tw = 0, dp = 0, rej;
  logic [4:0] wp = 0;
  logic [2:0] wd = 0;
  logic [31:0] go = 0, ge = 0, pi = 0, o, oe, gin, pu, en_m = 0;
  logic [31:0] r = 32'h843101dc, cap = `PM_TWO_WIRE_MASK;
  logic [7:0][31:0] fo = 0, fe = 0;
  logic [31:0][2:0] sel_m = 0;
  logic dbg_m = 0;
  logic [7:0][31:0] fin;
  logic [31:0] own_r;
  logic dbg_r, rdy;
  logic [99:0] exp_q[$];
  logic [288:0] exp_s[$];
  int fails = 0, compares = 0;
  event look;
  pin_mux_if cfg ();
  always #50 clk_sys = ~clk_sys;
  pin_mux_config i_pin_mux_config (.clk_sys, .resetn, .wr_valid(wv),
    .wr_ready(rdy), .wr_kind(wk), .wr_pin(wp), .wr_data(wd),
    .wr_two_wire(tw), .wr_reject_r(rej), .gpio_pullup_en_r(pu),
    .owned_by_periph_r(own_r), .debug_active_r(dbg_r), .cfg(cfg));
  port_pin_function_mux i_port_pin_function_mux (.clk_sys, .resetn,
    .cfg(cfg), .debugger_present(dp), .gpio_out(go), .gpio_oe(ge),
    .gpio_in_r(gin), .func_out(fo), .func_oe(fe), .func_in_r(fin),
    .pin_i(pi), .pin_o_r(o), .pin_oe_r(oe));
  pin_mux_checker i_pin_mux_checker (.clk_sys, .resetn,
    .peripheral_mux_enable(cfg.peripheral_mux_enable),
    .even_pin_function_select(cfg.even_pin_function_select),
    .odd_pin_function_select(cfg.odd_pin_function_select),
    .pin_owned_by_periph(cfg.pin_owned_by_periph),
    .debug_active(cfg.debug_active));
  // ==========================================================
  // reference
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] drv();
    logic [63:0] v;
    logic [2:0] c;
    logic w;
    for (int p = 0; p < 32; p++) begin
      w = dbg_m && p == 31;
      c = w ? 3'h6 : sel_m[p];
      w = w || (en_m[p] && c != 3'h5);
      v[p] = w ? fo[c][p] : go[p];
      v[32+p] = w ? fe[c][p] : ge[p];
    end
    return v;
  endfunction
  // sink side: {debug, ownership, pin level seen per function}
  function automatic logic [288:0] snk();
    logic [288:0] v;
    logic [2:0] c;
    logic w;
    v = '0;
    for (int p = 0; p < 32; p++) begin
      w = dbg_m && p == 31;
      c = w ? 3'h6 : sel_m[p];
      w = w || (en_m[p] && c != 3'h5);
      v[256+p] = w;
      if (w) v[32*c+p] = pi[p];
    end
    v[288] = dbg_m;
    return v;
  endfunction
  task automatic push(input logic k, rj);
    exp_q.push_back({k, ~en_m[25:24], rj, pi, drv()});
    exp_s.push_back(snk());
    ->look;
  endtask
  // one request, then a look after each of the two edges that follow
  task automatic op(input logic v, k, input logic [4:0] p,
                    input logic [2:0] d, input logic t, g);
    logic rj;
    rj = v && k && t && !cap[p];
    @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      r = nx(r);
      fo[i] = r;
      r = nx(r);
      fe[i] = ~r;
    end
    go = nx(r);
    ge = nx(go);
    pi = nx(ge);
    r = pi;
    wv = v;
    wk = k;
    wp = p;
    wd = d;
    tw = t;
    dp = g;
    @(negedge clk_sys);
    wv = 0;
    push(1'b0, rj);
    if (v && !k) en_m[p] = d[0];
    if (v && k && !rj) sel_m[p] = d;
    dbg_m = g;
    @(negedge clk_sys);
    push(1'b1, 1'b0);
  endtask
  always @(look) begin
    logic [99:0] e;
    logic [288:0] s;
    logic [1:0] m;
    e = exp_q.pop_front();
    s = exp_s.pop_front();
    m = {2{e[99]}};
    compares++;
    if ({e[98:97] & m, e[96:0]} !==
        {pu[25:24] & m, rej, gin, oe, o}) begin
      fails++;
      $display("Error at %0t: pin outputs differ", $time);
    end
    if (s !== {dbg_r, own_r, fin} || rdy !== 1'b1) begin
      fails++;
      $display("Error at %0t: sink side or status differs", $time);
    end
  end
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1;
    op(0, 0, 0, 0, 0, 0);
    op(1, 0, 4, 1, 0, 0);
    op(1, 0, 5, 1, 0, 0);
    for (int c = 0; c < 8; c++) begin
      op(1, 1, 4, 3'(c), 0, 0);
      op(1, 1, 5, 3'(7 - c), 0, 0);
    end
    op(1, 1, 14, 2, 1, 0);
    op(1, 1, 13, 2, 1, 0);
    op(1, 0, 24, 1, 0, 0);
    op(1, 0, 24, 0, 0, 0);
    op(0, 0, 0, 0, 0, 1);
    op(0, 0, 0, 0, 0, 0);
    repeat (40) begin
      r = nx(r);
      op(1, r[0], r[5:1], r[8:6], r[9], r[10]);
    end
    complete_run();
  end
endmodule
`default_nettype wire
